//--- rtl/dsc_regs.sv
// dsc_regs: AXI4-Lite register bank for pll multiplier, sync masks and two filter pages
`timescale 1ns/1ps
`default_nettype none
// Operation
// - the two-bit multiplier field picks 20x, 16x, 40x or 80x for codes 0 to 3.
// - with bit 6 clear a sync rising edge resets the clock divider, with it set sync is ignored.
// - with bit 5 clear a sync rising edge resets nco phase and lmfc counter, else both ignore it.
// - the filter page sits at base 5000h for channel a and 5800h for channel b, one copy each.
// - enable bit 0 means bypass and 1 routes samples through the decimation filter.
// - the four-bit ratio field maps codes to 4,6,8,9,10,12,16,18,20,24 and 32, codes 6, 11 and 13 to 15 unused.
// - the band bit selects single band at 0 and dual band at 1.
module dsc_regs (
  input  wire logic                  aclk,          // 125 MHz clock
  input  wire logic                  aresetn,       // sync reset, active low
  input  wire logic [17:0]           s_awaddr,      // write address
  input  wire logic                  s_awvalid,     // write address valid
  output logic                       s_awready,     // write address ready
  input  wire logic [31:0]           s_wdata,       // write data
  input  wire logic [3:0]            s_wstrb,       // byte strobes
  input  wire logic                  s_wvalid,      // write data valid
  output logic                       s_wready,      // write data ready
  output logic [1:0]                 s_bresp,       // write response
  output logic                       s_bvalid,      // write response valid
  input  wire logic                  s_bready,      // write response ready
  input  wire logic [17:0]           s_araddr,      // read address
  input  wire logic                  s_arvalid,     // read address valid
  output logic                       s_arready,     // read address ready
  output logic [31:0]                s_rdata,       // read data
  output logic [1:0]                 s_rresp,       // read response
  output logic                       s_rvalid,      // read data valid
  input  wire logic                  s_rready,      // read data ready
  input  wire logic                  sysref,        // sync reference input
  output dsc_pkg::dsc_mult_t         pll_mult,      // pll multiplier code
  output logic [6:0]                 pll_factor,    // multiplication factor
  output dsc_pkg::dsc_sync_t         sync_pulse,    // gated sync resets, one cycle
  output dsc_pkg::dsc_chan_cfg_t     chan_a_cfg,    // channel a filter setup
  output dsc_pkg::dsc_chan_cfg_t     chan_b_cfg     // channel b filter setup
);
  // ------------------------------------------------------------
  // write channel capture: address and data in either order
  // ------------------------------------------------------------
  logic [15:0] aw_idx_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic        w_byte0_r;
  logic        w_have_r;
  logic        wr_fire;
  logic [1:0]  mult_r;
  logic        clkdiv_mask_r;
  logic        osc_mask_r;
  logic        sysref_d_r;
  logic        sysref_rise;
  logic        jesd_wr;
  logic        wr_hit;
  logic [7:0]  wr_byte;
  logic        page_a_sel;
  logic        page_b_sel;
  logic [7:0]  a_rd;
  logic [7:0]  b_rd;
  logic        a_hit;
  logic        b_hit;
  logic [15:0] ar_idx;
  logic [7:0]  jesd_rd;
  logic        jesd_hit;
  logic        rd_hit;
  logic [7:0]  rd_byte;

  assign s_awready = !aw_have_r && !s_bvalid;
  assign s_wready  = !w_have_r && !s_bvalid;
  assign wr_fire   = aw_have_r && w_have_r && !s_bvalid;
  assign wr_byte   = w_byte0_r ? w_data_r[7:0] : dsc_pkg::RST_REG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_idx_r  <= 16'h0000;
    end else if (s_awvalid && s_awready) begin
      aw_have_r <= 1'b1;
      aw_idx_r  <= s_awaddr[17:2];
    end else if (wr_fire) begin
      aw_have_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_byte0_r <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_have_r  <= 1'b1;
      w_data_r  <= s_wdata;
      w_byte0_r <= s_wstrb[0];
    end else if (wr_fire) begin
      w_have_r <= 1'b0;
    end
  end

  // address decode: jesd page at low indices, filter pages by base
  assign page_a_sel = (aw_idx_r & dsc_pkg::IDX_PAGE_MASK) == dsc_pkg::IDX_PAGE_A;
  assign page_b_sel = (aw_idx_r & dsc_pkg::IDX_PAGE_MASK) == dsc_pkg::IDX_PAGE_B;
  assign jesd_wr    = (aw_idx_r == dsc_pkg::IDX_PLL_MULT) || (aw_idx_r == dsc_pkg::IDX_SYNC_MASK);
  assign wr_hit     = jesd_wr || (page_a_sel && aw_idx_r[10:0] <= dsc_pkg::IDX_BAND_COUNT[10:0])
                      || (page_b_sel && aw_idx_r[10:0] <= dsc_pkg::IDX_BAND_COUNT[10:0]);

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= dsc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // jesd page registers; reserved bits dropped, read as zero
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mult_r        <= dsc_pkg::RST_REG[1:0];
      clkdiv_mask_r <= dsc_pkg::RST_REG[0];
      osc_mask_r    <= dsc_pkg::RST_REG[0];
    end else if (wr_fire) begin
      if (aw_idx_r == dsc_pkg::IDX_PLL_MULT) begin
        mult_r <= wr_byte[1:0] & dsc_pkg::WMASK_PLL[1:0];
      end
      if (aw_idx_r == dsc_pkg::IDX_SYNC_MASK) begin
        clkdiv_mask_r <= wr_byte[dsc_pkg::POS_CLKDIV_MASK];
        osc_mask_r    <= wr_byte[dsc_pkg::POS_OSC_MASK];
      end
    end
  end

  // multiplier decode; 40x/80x companions live in register 16h, outside here
  assign pll_mult = dsc_pkg::dsc_mult_t'(mult_r);
  always_comb begin
    case (pll_mult)
      dsc_pkg::DSC_MUL_20: pll_factor = 7'd20;
      dsc_pkg::DSC_MUL_16: pll_factor = 7'd16;
      dsc_pkg::DSC_MUL_40: pll_factor = 7'd40;
      dsc_pkg::DSC_MUL_80: pll_factor = 7'd80;
      default:             pll_factor = 7'd20;
    endcase
  end

  // ------------------------------------------------------------
  // sync edge detect and masking
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysref_d_r <= 1'b0;
    end else begin
      sysref_d_r <= sysref;
    end
  end
  // only the low-to-high transition counts, a held level does nothing
  assign sysref_rise = sysref && !sysref_d_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_pulse <= '0;
    end else begin
      sync_pulse.clkdiv_reset <= sysref_rise && !clkdiv_mask_r;
      sync_pulse.nco_reset    <= sysref_rise && !osc_mask_r;
      sync_pulse.lmfc_reset   <= sysref_rise && !osc_mask_r;
    end
  end

  // ------------------------------------------------------------
  // per-channel filter pages, one copy each
  // ------------------------------------------------------------
  assign ar_idx = s_araddr[17:2];

  dsc_chan_cfg u_chan_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && page_a_sel),
    .wr_ofs  (aw_idx_r & dsc_pkg::IDX_OFS_MASK),
    .wr_data (wr_byte),
    .rd_ofs  (ar_idx & dsc_pkg::IDX_OFS_MASK),
    .rd_data (a_rd),
    .rd_hit  (a_hit),
    .cfg     (chan_a_cfg)
  );

  dsc_chan_cfg u_chan_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_fire && page_b_sel),
    .wr_ofs  (aw_idx_r & dsc_pkg::IDX_OFS_MASK),
    .wr_data (wr_byte),
    .rd_ofs  (ar_idx & dsc_pkg::IDX_OFS_MASK),
    .rd_data (b_rd),
    .rd_hit  (b_hit),
    .cfg     (chan_b_cfg)
  );

  // ------------------------------------------------------------
  // read channel: one cycle after the address is taken
  // ------------------------------------------------------------
  always_comb begin
    jesd_hit = 1'b1;
    jesd_rd  = 8'h00;
    case (ar_idx)
      dsc_pkg::IDX_PLL_MULT:  jesd_rd = {6'h00, mult_r};
      dsc_pkg::IDX_SYNC_MASK: jesd_rd = {1'b0, clkdiv_mask_r, osc_mask_r, 5'h00};
      default:                jesd_hit = 1'b0;
    endcase
    if ((ar_idx & dsc_pkg::IDX_PAGE_MASK) == dsc_pkg::IDX_PAGE_A) begin
      rd_hit  = a_hit;
      rd_byte = a_rd;
    end else if ((ar_idx & dsc_pkg::IDX_PAGE_MASK) == dsc_pkg::IDX_PAGE_B) begin
      rd_hit  = b_hit;
      rd_byte = b_rd;
    end else begin
      rd_hit  = jesd_hit;
      rd_byte = jesd_rd;
    end
  end

  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= dsc_pkg::RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= {24'h000000, rd_byte};
      s_rresp  <= rd_hit ? dsc_pkg::RESP_OKAY : dsc_pkg::RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_CLKDIV_MASKED: assert property (@(posedge aclk) disable iff (!aresetn)
    (sysref && !$past(sysref) && clkdiv_mask_r && $past(aresetn)) |=> !sync_pulse.clkdiv_reset)
    else $error("clock divider reset despite mask");
  AST_CLKDIV_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    (sysref && !sysref_d_r && !clkdiv_mask_r) |=> sync_pulse.clkdiv_reset)
    else $error("clock divider not reset on sync edge");
  AST_OSC_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_pulse.nco_reset |-> $past(sysref_rise && !osc_mask_r) && sync_pulse.lmfc_reset)
    else $error("nco or lmfc reset mismatch");
  AST_PULSE_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_pulse.clkdiv_reset |=> !sync_pulse.clkdiv_reset)
    else $error("sync pulse longer than one cycle");
  AST_PLL_FACTOR: assert property (@(posedge aclk) disable iff (!aresetn)
    (mult_r == 2'h2) |-> (pll_factor == 7'd40))
    else $error("40x code decoded wrong");
  AST_PLL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_idx_r == dsc_pkg::IDX_PLL_MULT && w_byte0_r) |=> mult_r == $past(w_data_r[1:0]))
    else $error("multiplier write lost");
  AST_PAGE_A: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && aw_idx_r == (dsc_pkg::IDX_PAGE_A | dsc_pkg::IDX_DC_ENABLE) && w_byte0_r)
      |=> chan_a_cfg.filter_on == $past(w_data_r[0]))
    else $error("channel a enable not written");
  AST_PAGE_B_ISOL: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && page_a_sel) |=> $stable(chan_b_cfg))
    else $error("channel a write disturbed channel b");
  AST_RATIO_24: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && page_b_sel && aw_idx_r[10:0] == dsc_pkg::IDX_DECIM_RATIO[10:0]
      && w_byte0_r && w_data_r[3:0] == 4'ha) |=> chan_b_cfg.ratio == 6'h18)
    else $error("ratio code 1010 not 24");
  AST_RATIO_UNUSED: assert property (@(posedge aclk) disable iff (!aresetn)
    (chan_a_cfg.ratio_valid == 1'b0) |-> (chan_a_cfg.ratio == 6'h00))
    else $error("unused ratio code gave a ratio");
  AST_BAND: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && page_a_sel && aw_idx_r[10:0] == dsc_pkg::IDX_BAND_COUNT[10:0] && w_byte0_r)
      |=> chan_a_cfg.dual_band == $past(w_data_r[0]))
    else $error("band select not written");
endmodule
`default_nettype wire

//--- rtl/dsc_pkg.sv
// dsc_pkg: register map, field layout and decoded types for the sync/config register bank
package dsc_pkg;
  // ----------------------------------------------------------------
  // register indices (printed offsets, not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_JESD_PAGE     = 16'h0000;
  localparam logic [15:0] IDX_PAGE_A        = 16'h5000;
  localparam logic [15:0] IDX_PAGE_B        = 16'h5800;
  localparam logic [15:0] IDX_PLL_MULT      = 16'h0037;
  localparam logic [15:0] IDX_SYNC_MASK     = 16'h003e;
  localparam logic [15:0] IDX_DC_ENABLE     = 16'h0000;
  localparam logic [15:0] IDX_DECIM_RATIO   = 16'h0001;
  localparam logic [15:0] IDX_BAND_COUNT    = 16'h0002;
  localparam logic [15:0] IDX_PAGE_MASK     = 16'hf800;
  localparam logic [15:0] IDX_OFS_MASK      = 16'h07ff;
  localparam int          ADDR_W            = 18;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG            = 8'h00;
  localparam int         POS_CLKDIV_MASK    = 6;
  localparam int         POS_OSC_MASK       = 5;
  localparam logic [7:0] WMASK_PLL          = 8'h03;
  localparam logic [7:0] WMASK_SYNC         = 8'h60;
  localparam logic [7:0] WMASK_BIT0         = 8'h01;
  localparam logic [7:0] WMASK_DECIM        = 8'h0f;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;

  // pll multiplication factor codes
  typedef enum logic [1:0] {
    DSC_MUL_20 = 2'h0,
    DSC_MUL_16 = 2'h1,
    DSC_MUL_40 = 2'h2,
    DSC_MUL_80 = 2'h3
  } dsc_mult_t;

  // per-channel decoded filter setup
  typedef struct packed {
    logic       filter_on;    // 0 = bypass
    logic       dual_band;    // 0 = single band
    logic       ratio_valid;  // code is a defined ratio
    logic [5:0] ratio;        // complex decimation ratio
  } dsc_chan_cfg_t;

  // sync pulse fan-out
  typedef struct packed {
    logic clkdiv_reset;
    logic nco_reset;
    logic lmfc_reset;
  } dsc_sync_t;
endpackage

//--- rtl/dsc_chan_cfg.sv
// dsc_chan_cfg: one channel's decimation filter page and its decode
`timescale 1ns/1ps
`default_nettype none
module dsc_chan_cfg (
  input  wire logic                  aclk,     // system clock
  input  wire logic                  aresetn,  // sync reset, active low
  input  wire logic                  wr_en,    // write strobe for this page
  input  wire logic [15:0]           wr_ofs,   // offset within page
  input  wire logic [7:0]            wr_data,  // write byte
  input  wire logic [15:0]           rd_ofs,   // read offset within page
  output logic      [7:0]            rd_data,  // read byte
  output logic                       rd_hit,   // read offset mapped
  output dsc_pkg::dsc_chan_cfg_t     cfg       // decoded setup
);
  logic       enable_r;
  logic [3:0] ratio_sel_r;
  logic       band_r;

  // ------------------------------------------------------------
  // page registers; reserved bits are not stored
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r    <= dsc_pkg::RST_REG[0];
      ratio_sel_r <= dsc_pkg::RST_REG[3:0];
      band_r      <= dsc_pkg::RST_REG[0];
    end else if (wr_en) begin
      if (wr_ofs == dsc_pkg::IDX_DC_ENABLE) begin
        enable_r <= wr_data[0];
      end
      if (wr_ofs == dsc_pkg::IDX_DECIM_RATIO) begin
        ratio_sel_r <= wr_data[3:0] & dsc_pkg::WMASK_DECIM[3:0];
      end
      if (wr_ofs == dsc_pkg::IDX_BAND_COUNT) begin
        band_r <= wr_data[0];
      end
    end
  end

  // read back of stored fields
  always_comb begin
    rd_data = 8'h00;
    rd_hit  = 1'b1;
    case (rd_ofs)
      dsc_pkg::IDX_DC_ENABLE:   rd_data = {7'h00, enable_r};
      dsc_pkg::IDX_DECIM_RATIO: rd_data = {4'h0, ratio_sel_r};
      dsc_pkg::IDX_BAND_COUNT:  rd_data = {7'h00, band_r};
      default:                  rd_hit  = 1'b0;
    endcase
  end

  // ratio decode; unused codes flag invalid and keep ratio zero
  always_comb begin
    cfg.filter_on   = enable_r;
    cfg.dual_band   = band_r;
    cfg.ratio_valid = 1'b1;
    case (ratio_sel_r)
      4'h0:    cfg.ratio = 6'h04;
      4'h1:    cfg.ratio = 6'h06;
      4'h2:    cfg.ratio = 6'h08;
      4'h3:    cfg.ratio = 6'h09;
      4'h4:    cfg.ratio = 6'h0a;
      4'h5:    cfg.ratio = 6'h0c;
      4'h7:    cfg.ratio = 6'h10;
      4'h8:    cfg.ratio = 6'h12;
      4'h9:    cfg.ratio = 6'h14;
      4'ha:    cfg.ratio = 6'h18;
      4'hc:    cfg.ratio = 6'h20;
      default: begin
        cfg.ratio       = 6'h00;
        cfg.ratio_valid = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

//--- verification/dsc_regs_tb.sv
// self-checking bench for the sync/config register bank over its axi4-lite port
`timescale 1ns/1ps
`default_nettype none
module downconverter_sync_config_regs_test;
  // ----------------------------------------------------------------
  // clock, reset and design wiring
  // ----------------------------------------------------------------
  logic                   aclk = 1'b0;
  logic                   aresetn = 1'b0;
  logic [17:0]            s_awaddr = 18'h0, s_araddr = 18'h0;
  logic                   s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic                   s_arvalid = 1'b0, s_rready = 1'b0, sysref = 1'b0;
  logic [31:0]            s_wdata = 32'h0;
  logic [3:0]             s_wstrb = 4'h0;
  logic                   s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]             s_bresp, s_rresp;
  logic [31:0]            s_rdata;
  dsc_pkg::dsc_mult_t     pll_mult;
  logic [6:0]             pll_factor;
  dsc_pkg::dsc_sync_t     sync_pulse;
  dsc_pkg::dsc_chan_cfg_t chan_a_cfg, chan_b_cfg;
  int                     miscompares = 0;
  int                     comparisons = 0;
  // ratio per code, 0 marks an unused code
  logic [5:0] rat_tab [16] = '{6'h04, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0c, 6'h00, 6'h10,
                               6'h12, 6'h14, 6'h18, 6'h00, 6'h20, 6'h00, 6'h00, 6'h00};
  logic [6:0] fac_tab [4] = '{7'h14, 7'h10, 7'h28, 7'h50};
  localparam logic [17:0] A_PLL = 18'h000dc, A_SYNC = 18'h000f8;
  localparam logic [17:0] A_PGA = 18'h14000, A_PGB = 18'h16000, A_BAD = 18'h1400c;
  // companion multiplier register, held outside this bank
  localparam logic [17:0] A_CMP = 18'h00058;
  // high multiplier mode bit in the companion register; value arbitrary
  localparam logic [7:0]  HI_MULT_BIT = 8'h01;

  // 125 MHz clock
  always #4 aclk = ~aclk;

  dsc_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .sysref(sysref),
    .pll_mult(pll_mult), .pll_factor(pll_factor), .sync_pulse(sync_pulse),
    .chan_a_cfg(chan_a_cfg), .chan_b_cfg(chan_b_cfg));

  // ----------------------------------------------------------------
  // compare tasks and verdict
  // ----------------------------------------------------------------
  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic check_cfg(input string name, input dsc_pkg::dsc_chan_cfg_t exp,
                           input dsc_pkg::dsc_chan_cfg_t got);
    check_word(name, {23'h0, exp}, {23'h0, got});
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus master: handshakes are judged at the rising edge where the slave
  // samples them, and every change is made just after that edge
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [17:0] addr, input logic [7:0] data,
                           input logic [3:0] strb, input logic [1:0] exp_resp);
    logic a, w, b;
    logic [1:0] rsp;
    b = 1'b0;
    @(posedge aclk);
    s_awaddr  <= addr;
    s_awvalid <= 1'b1;
    s_wdata   <= {24'h0, data};
    s_wstrb   <= strb;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      a = s_awvalid && s_awready;
      w = s_wvalid && s_wready;
      b = s_bvalid && s_bready;
      rsp = s_bresp;
      if (a) s_awvalid <= 1'b0;
      if (w) s_wvalid <= 1'b0;
      if (b) s_bready <= 1'b0;
    end
    check_word("write response", {30'h0, exp_resp}, {30'h0, rsp});
  endtask

  task automatic axi_read(input logic [17:0] addr, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
    logic a, r;
    logic [31:0] dat;
    logic [1:0] rsp;
    r = 1'b0;
    @(posedge aclk);
    s_araddr  <= addr;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    while (!r) begin
      @(posedge aclk);
      a = s_arvalid && s_arready;
      r = s_rvalid && s_rready;
      dat = s_rdata;
      rsp = s_rresp;
      if (a) s_arvalid <= 1'b0;
      if (r) s_rready <= 1'b0;
    end
    check_word("read data", exp, dat);
    check_word("read response", {30'h0, exp_resp}, {30'h0, rsp});
  endtask

  // one sysref rise held high: exactly one pulse cycle on unmasked outputs
  task automatic sync_probe(input dsc_pkg::dsc_sync_t exp);
    int hits;
    dsc_pkg::dsc_sync_t seen;
    hits = 0;
    seen = '0;
    @(posedge aclk);
    sysref <= 1'b1;
    repeat (6) begin
      @(negedge aclk);
      if (sync_pulse !== 3'h0) hits++;
      seen = seen | sync_pulse;
    end
    @(posedge aclk);
    sysref <= 1'b0;
    repeat (3) @(posedge aclk);
    check_word("sync pulse set", {29'h0, exp}, {29'h0, seen});
    check_word("sync pulse cycles", {31'h0, exp != 3'h0}, 32'(hits));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    dsc_pkg::dsc_chan_cfg_t ecfg;
    logic [17:0] regs [8];
    regs = '{A_PLL, A_SYNC, A_PGA, A_PGA + 18'h4, A_PGA + 18'h8, A_PGB, A_PGB + 18'h4,
             A_PGB + 18'h8};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state of every register and decoded output
    check_word("pll factor", 32'h14, {25'h0, pll_factor});
    ecfg = '{filter_on: 1'b0, dual_band: 1'b0, ratio_valid: 1'b1, ratio: 6'h04};
    check_cfg("chan a reset", ecfg, chan_a_cfg);
    check_cfg("chan b reset", ecfg, chan_b_cfg);
    foreach (regs[i]) axi_read(regs[i], 32'h0, dsc_pkg::RESP_OKAY);
    // every multiplier code, each write checked and read back
    for (int c = 0; c < 4; c++) begin
      axi_write(A_PLL, 8'(c), 4'h1, dsc_pkg::RESP_OKAY);
      // companion setting lives outside this bank, so it is refused here
      if (c == 2) axi_write(A_CMP, 8'h70, 4'h1, dsc_pkg::RESP_SLVERR);
      if (c == 3) axi_write(A_CMP, HI_MULT_BIT, 4'h1, dsc_pkg::RESP_SLVERR);
      check_word("pll factor", {25'h0, fac_tab[c]}, {25'h0, pll_factor});
      check_word("pll code", 32'(c), {30'h0, pll_mult});
      axi_read(A_PLL, 32'(c), dsc_pkg::RESP_OKAY);
    end
    // all four mask combinations against a sysref rise
    for (int m = 0; m < 4; m++) begin
      axi_write(A_SYNC, 8'(m << 5), 4'h1, dsc_pkg::RESP_OKAY);
      axi_read(A_SYNC, 32'(m << 5), dsc_pkg::RESP_OKAY);
      sync_probe('{clkdiv_reset: !m[1], nco_reset: !m[0], lmfc_reset: !m[0]});
    end
    // channel a: filter on, dual band, every ratio code; channel b untouched
    axi_write(A_PGA, 8'h01, 4'h1, dsc_pkg::RESP_OKAY);
    axi_write(A_PGA + 18'h8, 8'h01, 4'h1, dsc_pkg::RESP_OKAY);
    for (int c = 0; c < 16; c++) begin
      axi_write(A_PGA + 18'h4, 8'(c), 4'h1, dsc_pkg::RESP_OKAY);
      ecfg = '{filter_on: 1'b1, dual_band: 1'b1, ratio_valid: rat_tab[c] != 6'h0,
               ratio: rat_tab[c]};
      check_cfg("chan a ratio", ecfg, chan_a_cfg);
      axi_read(A_PGA + 18'h4, 32'(c), dsc_pkg::RESP_OKAY);
    end
    ecfg = '{filter_on: 1'b0, dual_band: 1'b0, ratio_valid: 1'b1, ratio: 6'h04};
    check_cfg("chan b kept", ecfg, chan_b_cfg);
    // channel b gets its own setup; a keeps filter and ratio but goes back to single band
    axi_write(A_PGB, 8'h01, 4'h1, dsc_pkg::RESP_OKAY);
    axi_write(A_PGB + 18'h4, 8'h0a, 4'h1, dsc_pkg::RESP_OKAY);
    ecfg = '{filter_on: 1'b1, dual_band: 1'b0, ratio_valid: 1'b1, ratio: 6'h18};
    check_cfg("chan b setup", ecfg, chan_b_cfg);
    axi_write(A_PGA + 18'h8, 8'h00, 4'h1, dsc_pkg::RESP_OKAY);
    ecfg = '{filter_on: 1'b1, dual_band: 1'b0, ratio_valid: 1'b0, ratio: 6'h00};
    check_cfg("chan a single", ecfg, chan_a_cfg);
    // cleared low strobe writes zero; bypass comes back
    axi_write(A_PGA, 8'h01, 4'h0, dsc_pkg::RESP_OKAY);
    check_word("chan a filter", 32'h0, {31'h0, chan_a_cfg.filter_on});
    axi_read(A_PGA, 32'h0, dsc_pkg::RESP_OKAY);
    // unmapped place is refused and leaves the map alone
    axi_write(A_BAD, 8'h01, 4'h1, dsc_pkg::RESP_SLVERR);
    axi_read(A_BAD, 32'h0, dsc_pkg::RESP_SLVERR);
    axi_read(A_PGB + 18'h4, 32'h0a, dsc_pkg::RESP_OKAY);
    // mid-run reset: pll factor, channel b setup and sync masks fall back to their reset values
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ecfg = '{filter_on: 1'b0, dual_band: 1'b0, ratio_valid: 1'b1, ratio: 6'h04};
    check_word("pll factor", 32'h14, {25'h0, pll_factor});
    check_cfg("chan b reset", ecfg, chan_b_cfg);
    axi_read(A_SYNC, 32'h0, dsc_pkg::RESP_OKAY);
    print_verdict();
  end

  // hang guard, far above the few hundred cycles the tests need
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
